//--- include/sqr_pkg.sv
// shared types and constants of the serial queue unit
package sqr_pkg;

    // control bits kept by the processor side
    typedef struct packed {
        logic tx_irq_en;
        logic rx_irq_en;
        logic err_irq_en;
        logic fault_detect_en;
        logic serial_unit_on;
        logic master_select;
        logic open_drain_sel;
        logic clock_pol;
        logic clock_phase;
        logic [1:0] baud_sel;
    } sqr_cfg_t;

    // status flags as the processor reads them
    typedef struct packed {
        logic rx_full_flag;
        logic overrun_flag;
        logic mode_fault_flag;
        logic tx_empty_flag;
    } sqr_status_t;

    // master engine states, gray along idle -> shift
    typedef enum logic [1:0] {
        SQR_IDLE = 2'h0,
        SQR_SHIFT = 2'h1
    } sqr_mstate_t;

    // values after system reset: master, phase 1, everything else off
    localparam sqr_cfg_t CFG_RESET = '{
        tx_irq_en: 1'h0,
        rx_irq_en: 1'h0,
        err_irq_en: 1'h0,
        fault_detect_en: 1'h0,
        serial_unit_on: 1'h0,
        master_select: 1'h1,
        open_drain_sel: 1'h0,
        clock_pol: 1'h0,
        clock_phase: 1'h1,
        baud_sel: 2'h0
    };

    localparam int BYTE_BITS = 8;

    // half serial clock period in bus cycles for baud_sel 0..3
    localparam logic [6:0] HALF_DIV2 = 7'h01;
    localparam logic [6:0] HALF_DIV8 = 7'h04;
    localparam logic [6:0] HALF_DIV32 = 7'h10;
    localparam logic [6:0] HALF_DIV128 = 7'h40;

endpackage

//--- hdl/sqr_spi.sv
// serial peripheral unit: queued transmit, receive, flags, requests, pin ownership
// How it works
// - tx request when empty flag and enable
// - rx request on full flag, only while on
// - overrun/fault request needs both error and rx enables
// - no fault detect, no mode fault flag
// - receive buffer move sets rx full flag
// - move into shift register sets tx empty
// - queued byte follows previous one without gap
// - data write loads buffer, clears tx empty
// - status read then data read clears rx full
// - slave repeats shift register when nothing queued
// - unit off: empty set, abort, clear, pins released
// - control bits and flags not cleared by unit off
// - master mode fault switches the unit off
// - wait mode keeps running, requests wake processor
// - stop halts master holding state, slave shifter keeps receiving, reset aborts transfer
// - break without clear allow freezes flags and writes
// - open drain select makes master data open drain
// - slave data driven only when selected as slave
// - deselected slave ignores serial clock edges
// - unit owns pins, eight clocks per byte
// - slave select dedicated as slave or fault master
// - unread byte at next capture sets overrun, discards
// - fault master sets mode fault on select low
// - slave select rising mid transfer sets fault, with phase 0 any rise does
`timescale 1ns/100ps
module sqr_spi #(
    parameter int BYTE_W = sqr_pkg::BYTE_BITS
) (
    // clocks and reset
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic link_sck,
    // processor side
    input wire logic cfg_wr,
    input wire sqr_pkg::sqr_cfg_t cfg_wdata,
    input wire logic status_rd,
    input wire logic data_rd,
    input wire logic data_wr,
    input wire logic [BYTE_W-1:0] wdata,
    output sqr_pkg::sqr_cfg_t cfg,
    output sqr_pkg::sqr_status_t status,
    output logic [BYTE_W-1:0] rdata,
    // system state and requests
    input wire logic break_state,
    input wire logic break_clear_allow,
    input wire logic stop_mode,
    output logic tx_irq,
    output logic rx_err_irq,
    output logic wake_req,
    // pins
    input wire logic mosi_in,
    input wire logic miso_in,
    input wire logic ss_n_in,
    output logic mosi_out,
    output logic mosi_oe_n,
    output logic miso_out,
    output logic miso_oe_n,
    output logic sck_out,
    output logic sck_oe_n,
    output logic ss_owned,
    output logic pins_owned
);
    localparam int LCW = $clog2(BYTE_W);
    localparam int ECW = LCW + 1;
    localparam logic [LCW-1:0] LAST_BIT = LCW'(BYTE_W - 1);
    localparam logic [ECW-1:0] LAST_EDGE = ECW'(2 * BYTE_W - 1);

    generate
        if (BYTE_W < 2 || BYTE_W > 16) begin : g_bad_width
            $error("sqr_spi: BYTE_W must be 2 to 16");
        end
    endgenerate

    // processor side state
    logic tx_full;
    logic [BYTE_W-1:0] tx_buf;
    logic [BYTE_W-1:0] rx_data;
    logic rx_full;
    logic overrun;
    logic mode_fault;
    logic rx_arm;
    logic ovr_arm;
    logic mode_fault_flag_arm;
    logic [BYTE_W-1:0] slave_word;
    logic req;
    // synchronisers into sys_clk
    logic ss_m, ss_s, ss_q;
    logic miso_m, miso_s;
    logic ack_m, ack_s;
    logic done_m, done_s, done_q;
    logic busy_m, busy_s;
    // master engine
    sqr_pkg::sqr_mstate_t mstate;
    logic [ECW-1:0] edge_cnt;
    logic [6:0] div_cnt;
    logic [6:0] half;
    logic [BYTE_W-1:0] msh;
    logic sck_q;
    logic mosi_q;
    // link domain
    logic link_on;
    logic link_clr_n;
    logic req_lm, req_ls;
    logic [BYTE_W-1:0] lsh;
    logic [BYTE_W-1:0] next_lsh;
    logic [LCW-1:0] lcnt;
    logic ack;
    logic done_tgl;
    logic l_busy;
    logic [BYTE_W-1:0] rx_word;
    logic miso_q;

    // combinational helpers
    logic unit_on, master_on, slave_on, clr_ok, wr_ok, tick, m_done, m_load, s_load;
    logic s_done, rx_move, mode_fault_flag_cond, ss_rise;
    logic [BYTE_W-1:0] m_rx, rx_byte;

    assign unit_on = cfg.serial_unit_on;
    assign master_on = unit_on & cfg.master_select;
    assign slave_on = unit_on & ~cfg.master_select;
    // flags and the data buffer are frozen during break unless allowed
    assign clr_ok = ~break_state | break_clear_allow;
    assign wr_ok = data_wr & clr_ok;

    always_comb begin
        case (cfg.baud_sel)
            2'h0: half = sqr_pkg::HALF_DIV2;
            2'h1: half = sqr_pkg::HALF_DIV8;
            2'h2: half = sqr_pkg::HALF_DIV32;
            default: half = sqr_pkg::HALF_DIV128;
        endcase
    end

    assign tick = (mstate == sqr_pkg::SQR_SHIFT) && (div_cnt == half - 7'h01);
    assign m_done = master_on & ~stop_mode & tick & (edge_cnt == LAST_EDGE);
    // with phase 1 the last edge is a capture edge, so fold in the live bit
    assign m_rx = cfg.clock_phase ? {msh[BYTE_W-2:0], miso_s} : msh;
    assign m_load = master_on & ~stop_mode & tx_full
        & ((mstate == sqr_pkg::SQR_IDLE) | m_done);
    assign s_load = slave_on & ~stop_mode & tx_full & (req == ack_s);
    assign s_done = slave_on & (done_s != done_q);
    assign rx_move = m_done | s_done;
    assign rx_byte = m_done ? m_rx : rx_word;
    assign ss_rise = ss_s & ~ss_q;
    always_comb begin
        mode_fault_flag_cond = 1'b0;
        if (cfg.fault_detect_en) begin
            if (master_on) begin
                mode_fault_flag_cond = ~ss_s;
            end else if (slave_on) begin
                mode_fault_flag_cond = ss_rise & (~cfg.clock_phase | busy_s);
            end
        end
    end

    // pin inputs and link state into sys_clk, two flops each
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ss_m <= 1'b1;
            ss_s <= 1'b1;
            ss_q <= 1'b1;
            miso_m <= 1'b1;
            miso_s <= 1'b1;
            ack_m <= 1'b0;
            ack_s <= 1'b0;
            done_m <= 1'b0;
            done_s <= 1'b0;
            done_q <= 1'b0;
            busy_m <= 1'b0;
            busy_s <= 1'b0;
        end else begin
            ss_m <= ss_n_in;
            ss_s <= ss_m;
            ss_q <= ss_s;
            miso_m <= miso_in;
            miso_s <= miso_m;
            ack_m <= ack;
            ack_s <= ack_m;
            done_m <= done_tgl;
            done_s <= done_m;
            done_q <= done_s;
            busy_m <= l_busy;
            busy_s <= busy_m;
        end
    end

    // control bits: only system reset clears them, master mode fault clears the enable
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cfg <= sqr_pkg::CFG_RESET;
        end else begin
            if (cfg_wr) begin
                cfg <= cfg_wdata;
            end
            if (master_on & mode_fault_flag_cond) begin
                cfg.serial_unit_on <= 1'b0;
            end
        end
    end

    // transmit buffer
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            tx_full <= 1'b0;
            tx_buf <= '0;
        end else begin
            if (wr_ok) begin
                tx_buf <= wdata;
            end
            if (!unit_on) begin
                tx_full <= 1'b0;
            end else if (wr_ok) begin
                tx_full <= 1'b1;
            end else if (m_load | s_load) begin
                tx_full <= 1'b0;
            end
        end
    end

    // hand the queued byte to the slave shifter with a toggle request
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            slave_word <= '0;
            req <= 1'b0;
        end else if (s_load) begin
            slave_word <= tx_buf;
            req <= ~req;
        end
    end

    // receive buffer and its flag
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rx_data <= '0;
            rx_full <= 1'b0;
            rx_arm <= 1'b0;
        end else begin
            if (data_rd & rx_arm & clr_ok) begin
                rx_full <= 1'b0;
                rx_arm <= 1'b0;
            end else if (status_rd & rx_full) begin
                rx_arm <= 1'b1;
            end
            if (rx_move & ~rx_full) begin
                rx_data <= rx_byte;
                rx_full <= 1'b1;
            end
        end
    end

    // overrun: old byte kept, new one dropped
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            overrun <= 1'b0;
            ovr_arm <= 1'b0;
        end else begin
            if (data_rd & ovr_arm & clr_ok) begin
                overrun <= 1'b0;
                ovr_arm <= 1'b0;
            end else if (status_rd & overrun) begin
                ovr_arm <= 1'b1;
            end
            if (rx_move & rx_full) begin
                overrun <= 1'b1;
            end
        end
    end

    // mode fault: cleared by status read then control write with no fault present
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            mode_fault <= 1'b0;
            mode_fault_flag_arm <= 1'b0;
        end else begin
            if (cfg_wr & mode_fault_flag_arm & clr_ok & ~mode_fault_flag_cond) begin
                mode_fault <= 1'b0;
                mode_fault_flag_arm <= 1'b0;
            end else if (status_rd & mode_fault) begin
                mode_fault_flag_arm <= 1'b1;
            end
            if (mode_fault_flag_cond) begin
                mode_fault <= 1'b1;
            end
        end
    end

    // master engine: divided serial clock, stopped in stop mode
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            mstate <= sqr_pkg::SQR_IDLE;
            edge_cnt <= '0;
            div_cnt <= 7'h00;
            msh <= '0;
            sck_q <= 1'b0;
            mosi_q <= 1'b1;
        end else if (!master_on) begin
            mstate <= sqr_pkg::SQR_IDLE;
            edge_cnt <= '0;
            div_cnt <= 7'h00;
            msh <= '0;
            sck_q <= cfg.clock_pol;
        end else if (!stop_mode) begin
            case (mstate)
                sqr_pkg::SQR_IDLE: begin
                    sck_q <= cfg.clock_pol;
                    if (m_load) begin
                        msh <= tx_buf;
                        mosi_q <= tx_buf[BYTE_W-1];
                        edge_cnt <= '0;
                        div_cnt <= 7'h00;
                        mstate <= sqr_pkg::SQR_SHIFT;
                    end
                end
                sqr_pkg::SQR_SHIFT: begin
                    if (tick) begin
                        div_cnt <= 7'h00;
                        sck_q <= ~sck_q;
                        if (edge_cnt[0] == cfg.clock_phase) begin
                            msh <= {msh[BYTE_W-2:0], miso_s};
                        end else begin
                            mosi_q <= msh[BYTE_W-1];
                        end
                        if (edge_cnt == LAST_EDGE) begin
                            edge_cnt <= '0;
                            if (m_load) begin
                                msh <= tx_buf;
                                mosi_q <= tx_buf[BYTE_W-1];
                            end else begin
                                mstate <= sqr_pkg::SQR_IDLE;
                            end
                        end else begin
                            edge_cnt <= edge_cnt + 1'b1;
                        end
                    end else begin
                        div_cnt <= div_cnt + 7'h01;
                    end
                end
                default: begin
                    mstate <= sqr_pkg::SQR_IDLE;
                end
            endcase
        end
    end

    // serial clock is idle outside frames, so the slave enable clears the
    // shifter asynchronously instead of waiting for link clock edges
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            link_on <= 1'b0;
        end else begin
            link_on <= slave_on;
        end
    end
    assign link_clr_n = rstn & link_on;

    // link domain: slave shifter on the incoming serial clock
    always_ff @(posedge link_sck or negedge rstn) begin
        if (!rstn) begin
            req_lm <= 1'b0;
            req_ls <= 1'b0;
        end else begin
            req_lm <= req;
            req_ls <= req_lm;
        end
    end

    always_comb begin
        if (lcnt == '0 && req_ls != ack) begin
            next_lsh = {slave_word[BYTE_W-2:0], mosi_in};
        end else begin
            next_lsh = {lsh[BYTE_W-2:0], mosi_in};
        end
    end

    always_ff @(posedge link_sck or negedge link_clr_n) begin
        if (!link_clr_n) begin
            lsh <= '0;
            lcnt <= '0;
            l_busy <= 1'b0;
        end else if (!ss_n_in) begin
            lsh <= next_lsh;
            if (lcnt == LAST_BIT) begin
                lcnt <= '0;
                l_busy <= 1'b0;
            end else begin
                lcnt <= lcnt + 1'b1;
                l_busy <= 1'b1;
            end
        end
    end

    // handshake toggles survive a partial reset
    always_ff @(posedge link_sck or negedge rstn) begin
        if (!rstn) begin
            ack <= 1'b0;
            done_tgl <= 1'b0;
            rx_word <= '0;
        end else if (!ss_n_in) begin
            if (lcnt == '0 && req_ls != ack) begin
                ack <= req_ls;
            end
            if (lcnt == LAST_BIT) begin
                rx_word <= next_lsh;
                done_tgl <= ~done_tgl;
            end
        end
    end

    always_ff @(negedge link_sck or negedge rstn) begin
        if (!rstn) begin
            miso_q <= 1'b0;
        end else if (!ss_n_in) begin
            miso_q <= lsh[BYTE_W-1];
        end
    end

    // first bit is presented before any clock edge
    always_comb begin
        if (lcnt != '0) begin
            miso_out = miso_q;
        end else if (req_ls != ack) begin
            miso_out = slave_word[BYTE_W-1];
        end else begin
            miso_out = lsh[BYTE_W-1];
        end
    end

    // pins
    assign sck_out = sck_q;
    assign sck_oe_n = ~master_on;
    assign mosi_out = cfg.open_drain_sel ? 1'b0 : mosi_q;
    assign mosi_oe_n = ~master_on | (cfg.open_drain_sel & mosi_q);
    assign miso_oe_n = ~(slave_on & ~ss_s);
    assign ss_owned = unit_on & (~cfg.master_select | cfg.fault_detect_en);
    assign pins_owned = unit_on;

    // status and requests
    assign status.rx_full_flag = rx_full;
    assign status.overrun_flag = overrun;
    assign status.mode_fault_flag = mode_fault;
    assign status.tx_empty_flag = ~tx_full;
    assign rdata = rx_data;
    assign tx_irq = ~tx_full & cfg.tx_irq_en;
    assign rx_err_irq = (unit_on & rx_full & cfg.rx_irq_en)
        | (cfg.rx_irq_en & cfg.err_irq_en & (overrun | mode_fault));
    assign wake_req = tx_irq | rx_err_irq;

endmodule // sqr_spi

//--- bench/sqr_spi_asserts.sv
// assertion checker for the serial queue unit
`timescale 1ns/100ps
module sqr_spi_asserts (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // processor side
    input wire logic data_wr,
    input wire sqr_pkg::sqr_cfg_t cfg,
    input wire sqr_pkg::sqr_status_t status,
    input wire logic break_state,
    input wire logic break_clear_allow,
    input wire logic tx_irq,
    input wire logic rx_err_irq,
    // pins
    input wire logic ss_n_in,
    input wire logic mosi_out,
    input wire logic mosi_oe_n,
    input wire logic miso_oe_n,
    input wire logic sck_oe_n,
    input wire logic ss_owned,
    input wire logic pins_owned
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    logic frz;
    assign frz = break_state && !break_clear_allow;

    tx_req_a: assert property (tx_irq == (status.tx_empty_flag && cfg.tx_irq_en))
        else $error("tx request wrong");
    rx_req_a: assert property (rx_err_irq == (cfg.rx_irq_en &&
        (status.rx_full_flag && cfg.serial_unit_on || cfg.err_irq_en &&
        (status.overrun_flag || status.mode_fault_flag)))) else $error("rx request wrong");
    fault_gate_a: assert property ($rose(status.mode_fault_flag) |-> $past(cfg.fault_detect_en))
        else $error("fault without detect enable");
    wr_clear_a: assert property (data_wr && !frz && cfg.serial_unit_on && cfg.master_select
        && status.tx_empty_flag |=> !status.tx_empty_flag) else $error("write kept empty");
    frz_wr_a: assert property (data_wr && frz && status.tx_empty_flag |=> status.tx_empty_flag)
        else $error("frozen write acted");
    frz_flag_a: assert property (frz && status.rx_full_flag |=> status.rx_full_flag)
        else $error("frozen flag cleared");
    unit_off_a: assert property (!cfg.serial_unit_on [*2] |-> status.tx_empty_flag &&
        !pins_owned && mosi_oe_n && miso_oe_n && sck_oe_n) else $error("off unit holds pins");
    ss_own_a: assert property ($stable(cfg) |-> ss_owned == (cfg.serial_unit_on &&
        (!cfg.master_select || cfg.fault_detect_en))) else $error("select ownership wrong");
    fault_off_a: assert property ($rose(status.mode_fault_flag) && cfg.master_select
        |-> ##[0:2] !cfg.serial_unit_on) else $error("master fault left unit on");
    open_drain_a: assert property (cfg.open_drain_sel && !mosi_oe_n |-> !mosi_out)
        else $error("open drain drove high");
    miso_hiz_a: assert property ((ss_n_in || cfg.master_select) [*4] |-> miso_oe_n)
        else $error("slave data driven unselected");
endmodule // sqr_spi_asserts

bind sqr_spi sqr_spi_asserts u_sqr_spi_asserts (.sys_clk, .rstn, .data_wr, .cfg, .status,
    .break_state, .break_clear_allow, .tx_irq, .rx_err_irq, .ss_n_in, .mosi_out,
    .mosi_oe_n, .miso_oe_n, .sck_oe_n, .ss_owned, .pins_owned);

//--- bench/sqr_remote.sv
// far-end model: slave for master tests, master for slave tests
`timescale 1ns/100ps
module sqr_remote (
    // role and wire levels
    input wire logic slv,
    input wire logic sck_w,
    input wire logic mosi_w,
    input wire logic miso_w,
    // driven lines
    output logic link_sck,
    output logic rem_mosi,
    output logic rem_miso,
    output logic ss_n
);
    logic [7:0] slave_tx = 8'h00;
    logic [7:0] slave_rx = 8'h00;
    initial begin
        link_sck = 1'b1;
        rem_mosi = 1'b1;
        rem_miso = 1'b0;
        ss_n = 1'b1;
    end
    // slave role: shift out on the leading edge, capture on the trailing one
    always @(posedge sck_w) begin
        if (slv) begin
            rem_miso <= slave_tx[7];
            slave_tx <= {slave_tx[6:0], 1'b0};
        end
    end
    always @(negedge sck_w) begin
        if (slv) begin
            slave_rx <= {slave_rx[6:0], mosi_w};
        end
    end
    // master role: clock runs only inside a frame, select dropped per byte
    task automatic frame(input logic [7:0] tx, input logic sel, output logic [7:0] rx);
        ss_n = !sel;
        rem_miso = ~rem_miso;
        #400;
        for (int i = 7; i >= 0; i--) begin
            link_sck = 1'b0;
            rem_mosi = tx[i];
            #3;
            link_sck = 1'b1;
            rx = {rx[6:0], miso_w};
            #3;
        end
        #400;
        ss_n = 1'b1;
        // data line has a pull-up once released
        rem_mosi = 1'b1;
    endtask
endmodule // sqr_remote

//--- bench/spi_irq_queue_reset_pins_tb_top.sv
// self-checking bench for the serial queue unit
`timescale 1ns/100ps
module spi_irq_queue_reset_pins_tb_top;
    typedef struct packed {
        logic [2:0] en;
        logic [1:0] baud;
        logic [7:0] tx;
        logic [7:0] rep;
    } sqr_row_t;
    // enables {tx irq, rx irq, open drain}, rate, byte out, reply
    sqr_row_t rows [4] = '{'{3'h6, 2'h1, 8'hA5, 8'h5A}, '{3'h2, 2'h2, 8'h81, 8'h7E},
        '{3'h5, 2'h1, 8'h0F, 8'hF0}, '{3'h0, 2'h3, 8'hC6, 8'h39}};
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic cfg_wr = 1'b0;
    logic status_rd = 1'b0;
    logic data_rd = 1'b0;
    logic data_wr = 1'b0;
    logic break_state = 1'b0;
    logic break_clear_allow = 1'b0;
    logic stop_mode = 1'b0;
    logic slv = 1'b1;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata, got;
    sqr_pkg::sqr_cfg_t cfg_wdata = sqr_pkg::CFG_RESET;
    sqr_pkg::sqr_cfg_t cfg, c;
    sqr_pkg::sqr_status_t status;
    logic tx_irq, rx_err_irq, mosi_out, mosi_oe_n, miso_out, miso_oe_n, sck_out, sck_oe_n;
    logic ss_owned, pins_owned, link_sck, rem_mosi, rem_miso, ss_n, wake_req;
    int fails = 0;
    int checks = 0;
    int n;
    wire mosi_w = !mosi_oe_n ? mosi_out : rem_mosi;
    wire miso_w = !miso_oe_n ? miso_out : rem_miso;
    wire sck_w = !sck_oe_n ? sck_out : link_sck;

    initial forever #50 sys_clk = ~sys_clk;

    sqr_spi u_sqr_spi (.sys_clk, .rstn, .link_sck, .cfg_wr, .cfg_wdata, .status_rd,
        .data_rd, .data_wr, .wdata, .cfg, .status, .rdata, .break_state,
        .break_clear_allow, .stop_mode, .tx_irq, .rx_err_irq, .wake_req,
        .mosi_in(mosi_w), .miso_in(miso_w), .ss_n_in(ss_n), .mosi_out, .mosi_oe_n,
        .miso_out, .miso_oe_n, .sck_out, .sck_oe_n, .ss_owned, .pins_owned);
    sqr_remote u_sqr_remote (.slv, .sck_w, .mosi_w, .miso_w, .link_sck, .rem_mosi,
        .rem_miso, .ss_n);

    task automatic tick(input int k);
        repeat (k) @(negedge sys_clk);
    endtask
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic setcfg(input sqr_pkg::sqr_cfg_t v);
        cfg_wdata = v;
        cfg_wr = 1'b1;
        tick(1);
        cfg_wr = 1'b0;
        tick(1);
    endtask
    task automatic wr(input logic [7:0] b);
        wdata = b;
        data_wr = 1'b1;
        tick(1);
        data_wr = 1'b0;
    endtask
    task automatic sts();
        status_rd = 1'b1;
        tick(1);
        status_rd = 1'b0;
    endtask
    task automatic dat();
        data_rd = 1'b1;
        tick(1);
        data_rd = 1'b0;
    endtask
    task automatic wait_rx(input int lim);
        int k = 0;
        while (status.rx_full_flag !== 1'b1 && k < lim) begin
            tick(1);
            k++;
        end
        if (k >= lim) begin
            fails++;
            close_out();
        end
    endtask
    task automatic xfer(input logic [7:0] b);
        u_sqr_remote.frame(b, 1'b1, got);
        tick(1);
        wait_rx(20);
    endtask

    initial begin
        tick(6);
        rstn = 1'b1;
        tick(1);
        chk("cfg", cfg, sqr_pkg::CFG_RESET);
        chk("status", status, 4'h1);
        $display("done reset");
        foreach (rows[i]) begin
            c = sqr_pkg::CFG_RESET;
            c.serial_unit_on = 1'b1;
            {c.tx_irq_en, c.rx_irq_en, c.open_drain_sel} = rows[i].en;
            c.baud_sel = rows[i].baud;
            setcfg(c);
            u_sqr_remote.slave_tx = rows[i].rep;
            wr(rows[i].tx);
            wait_rx(2000);
            tick(2);
            chk("rx data", rdata, rows[i].rep);
            chk("far end", u_sqr_remote.slave_rx, rows[i].tx);
            chk("tx req", tx_irq, rows[i].en[2]);
            chk("rx req", rx_err_irq, rows[i].en[1]);
            chk("wake", wake_req, rows[i].en[2] | rows[i].en[1]);
            sts();
            dat();
            tick(1);
            chk("rx clear", status.rx_full_flag, 1'b0);
            $display("done row %0d", i);
        end
        c = sqr_pkg::CFG_RESET;
        c.serial_unit_on = 1'b1;
        c.rx_irq_en = 1'b1;
        c.err_irq_en = 1'b1;
        c.baud_sel = 2'h1;
        setcfg(c);
        u_sqr_remote.slave_tx = 8'hC3;
        wr(8'h11);
        tick(2);
        chk("tx empty", status.tx_empty_flag, 1'b1);
        wr(8'h22);
        wait_rx(200);
        n = 0;
        while (status.overrun_flag !== 1'b1 && n < 200) begin
            tick(1);
            n++;
        end
        chk("queue gap", n[7:0], 8'h40);
        chk("kept byte", rdata, 8'hC3);
        chk("err req", rx_err_irq, 1'b1);
        sts();
        break_state = 1'b1;
        dat();
        tick(1);
        chk("frozen flags", status[3:2], 2'h3);
        wr(8'h33);
        chk("frozen write", status.tx_empty_flag, 1'b1);
        break_state = 1'b0;
        dat();
        tick(1);
        chk("late clear", status[3:2], 2'h0);
        $display("done queue");
        break_state = 1'b1;
        break_clear_allow = 1'b1;
        stop_mode = 1'b1;
        wr(8'h44);
        chk("break write", status.tx_empty_flag, 1'b0);
        tick(40);
        chk("stop hold", status.tx_empty_flag, 1'b0);
        break_state = 1'b0;
        break_clear_allow = 1'b0;
        stop_mode = 1'b0;
        wait_rx(200);
        chk("resumed", u_sqr_remote.slave_rx, 8'h44);
        sts();
        dat();
        $display("done stop");
        setcfg(c);
        chk("ss free", ss_owned, 1'b0);
        u_sqr_remote.ss_n = 1'b0;
        tick(6);
        chk("no fault", status.mode_fault_flag, 1'b0);
        u_sqr_remote.ss_n = 1'b1;
        tick(4);
        c.fault_detect_en = 1'b1;
        setcfg(c);
        chk("ss kept", ss_owned, 1'b1);
        u_sqr_remote.ss_n = 1'b0;
        tick(6);
        chk("fault", status.mode_fault_flag, 1'b1);
        chk("unit off", cfg.serial_unit_on, 1'b0);
        chk("pins free", pins_owned, 1'b0);
        chk("fault req", rx_err_irq, 1'b1);
        u_sqr_remote.ss_n = 1'b1;
        tick(4);
        sts();
        setcfg(sqr_pkg::CFG_RESET);
        chk("fault clear", status.mode_fault_flag, 1'b0);
        $display("done fault");
        slv = 1'b0;
        c = sqr_pkg::CFG_RESET;
        c.master_select = 1'b0;
        c.clock_pol = 1'b1;
        c.serial_unit_on = 1'b1;
        setcfg(c);
        chk("miso idle", miso_oe_n, 1'b1);
        xfer(8'hA5);
        chk("slave rx", rdata, 8'hA5);
        sts();
        dat();
        xfer(8'h3C);
        chk("repeat", got, 8'hA5);
        sts();
        dat();
        u_sqr_remote.frame(8'hFF, 1'b0, got);
        tick(8);
        chk("deselected", status.rx_full_flag, 1'b0);
        xfer(8'h96);
        chk("ghost clocks", got, 8'h3C);
        chk("slave rx2", rdata, 8'h96);
        sts();
        dat();
        c.serial_unit_on = 1'b0;
        setcfg(c);
        c.serial_unit_on = 1'b1;
        setcfg(c);
        xfer(8'h00);
        chk("cleared shift", got, 8'h00);
        chk("ss slave", ss_owned, 1'b1);
        c.fault_detect_en = 1'b1;
        c.clock_phase = 1'b0;
        setcfg(c);
        u_sqr_remote.ss_n = 1'b0;
        tick(4);
        u_sqr_remote.ss_n = 1'b1;
        tick(4);
        chk("slave fault", status.mode_fault_flag, 1'b1);
        chk("slave on", cfg.serial_unit_on, 1'b1);
        $display("done slave");
        close_out();
    end
endmodule // spi_irq_queue_reset_pins_tb_top
